// ===== spc_ctrl.sv
// serial peripheral control, rate, interrupt and dma request logic
//
// Overview of operation
// RL1 - four interrupt sources merge into one request, level enables it
// RL2 - slave raises dma triggers on received byte and on transmit emptied
// RL3 - receive and transmit dma triggers are separate outputs
// RL4 - clock_double doubles master serial clock rate
// RL5 - nothing serial happens unless enable bit is set
// RL6 - data_order_lsb_first selects lsb first, else msb first
// RL7 - master select bit chooses master or slave operation
// RL8 - select pin driven low as input clears master select bit
// RL9 - mode field sets clock phase and polarity
// RL10 - idle clock low for rising leading edge, high for falling
// RL11 - prescaler divides by 4, 16, 64, 128 without doubling
// RL12 - prescaler divides by 2, 8, 32, 64 with doubling
// RL13 - prescaler has no effect in slave operation
// RL14 - unbuffered: irq_level enables transfer_flag interrupt, 7:2 read only
// RL15 - buffered: rx_complete_irq_en gates rx_complete_flag
// RL16 - buffered: tx_complete_irq_en gates tx_complete_flag
// RL17 - buffered: tx_empty_irq_en gates tx_empty_flag
// RL18 - buffered: select_loss_irq_en gates select_loss_flag
// RL19 - software writes zero to reserved interrupt control bits
// RL20 - transfer_flag set on byte done, cleared by vector or read-access pair
// RL21 - buffer_mode_sel picks unbuffered, reserved, buffered one or two
// RL22 - rx_complete_flag follows unread data, write one clears it
// RL23 - select_loss_flag set on forced slave unless select pin disabled
// RL24 - request high when level nonzero and an enabled flag is set
`timescale 1ns/10ps
`default_nettype none
module spc_ctrl
  import spc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register bus
  input wire spc_axi_req_s axi_req_in,
  output var spc_axi_rsp_s axi_rsp_out,
  // shift engine events, same clock
  input wire logic byte_done_in,
  input wire logic tx_done_in,
  input wire logic wr_collision_in,
  input wire logic rx_overrun_in,
  input wire logic rx_unread_in,
  input wire logic tx_buf_empty_in,
  input wire logic data_access_in,
  input wire logic shift_active_in,
  // interrupt controller
  input wire logic vector_ack_in,
  // slave select pin
  input wire logic select_n_in,
  input wire logic select_is_input_in,
  // serial format to shift engine
  output logic enable_out,
  output logic master_out,
  output logic lsb_first_out,
  output logic [1:0] mode_out,
  output logic sck_out,
  output logic sck_edge_out,
  // requests
  output logic irq_out,
  output logic [1:0] irq_level_out,
  output logic dma_rx_trig_out,
  output logic dma_tx_trig_out
);

  logic [7:0] ctrl_ff;
  logic [7:0] irqc_ff;
  logic [7:0] ctrl2_ff;
  logic xfer_flag_ff, wcol_flag_ff, arm_ff;
  logic rxc_flag_ff, txc_flag_ff, dre_flag_ff, ssl_flag_ff, ovf_flag_ff;
  logic sel_meta_ff, sel_sync_ff;
  logic dre_prev_ff;
  logic irq_ff, dma_rx_ff, dma_tx_ff;
  logic aw_got_ff, w_got_ff;
  logic [5:0] aw_idx_ff;
  logic [7:0] wdata_ff;
  logic wstrb0_ff;
  spc_axi_rsp_s rsp_ff;
  logic [6:0] half;
  logic buffered, slave_on, sel_lost, do_wr, ar_take, st_read;
  logic [7:0] st_val, rd_val;
  logic rd_ok, sck_run, any_src;

  // assertion clock and reset
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // decoded controls
  assign buffered = ctrl2_ff[SPC_C2_BUF_LO +: 2] != SPC_BUF_OFF; // RL21
  assign slave_on = ctrl_ff[SPC_CTRL_EN] & ~ctrl_ff[SPC_CTRL_MASTER];
  assign sel_lost = ctrl_ff[SPC_CTRL_EN] & ctrl_ff[SPC_CTRL_MASTER] &
    select_is_input_in & ~sel_sync_ff & ~ctrl2_ff[SPC_C2_SSD]; // RL8
  assign do_wr = aw_got_ff & w_got_ff & ~rsp_ff.bvalid;
  assign ar_take = axi_req_in.arvalid & rsp_ff.arready;
  assign st_read = ar_take && axi_req_in.araddr[7:2] == SPC_IDX_STAT &&
    axi_req_in.araddr[1:0] == 2'h0;
  assign sck_run = ctrl_ff[SPC_CTRL_EN] & ctrl_ff[SPC_CTRL_MASTER] &
    shift_active_in; // RL5 RL13

  // two stage synchroniser for the select pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_meta_ff <= 1'b1;
      sel_sync_ff <= 1'b1;
    end else begin
      sel_meta_ff <= select_n_in;
      sel_sync_ff <= sel_meta_ff;
    end
  end

  // prescaler half period select
  always_comb begin
    case ({ctrl_ff[SPC_CTRL_CLOCK_DOUBLE], ctrl_ff[SPC_CTRL_PRE_LO +: 2]})
      3'h0: half = SPC_HALF_N0; // RL11
      3'h1: half = SPC_HALF_N1; // RL11
      3'h2: half = SPC_HALF_N2; // RL11
      3'h3: half = SPC_HALF_N3; // RL11
      3'h4: half = SPC_HALF_D0; // RL4 RL12
      3'h5: half = SPC_HALF_D1; // RL12
      3'h6: half = SPC_HALF_D2; // RL12
      default: half = SPC_HALF_D3; // RL12
    endcase
  end

  // serial clock, idle level from mode high bit
  spc_sck_gen u_sck (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(sck_run),
    .idle_high_in(ctrl_ff[SPC_CTRL_MODE_LO + 1]), // RL9 RL10
    .half_in(half),
    .sck_out(sck_out),
    .edge_out(sck_edge_out)
  );

  // write address and data capture, either order
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_idx_ff <= 6'h00;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
    end else begin
      if (axi_req_in.awvalid && rsp_ff.awready) begin
        aw_got_ff <= 1'b1;
        aw_idx_ff <= axi_req_in.awaddr[7:2];
      end else if (do_wr) begin
        aw_got_ff <= 1'b0;
      end
      if (axi_req_in.wvalid && rsp_ff.wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= axi_req_in.wdata[7:0];
        wstrb0_ff <= axi_req_in.wstrb[0];
      end else if (do_wr) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  // read mux
  always_comb begin
    st_val = 8'h00;
    if (buffered) begin
      st_val[SPC_ST_B7] = rxc_flag_ff;
      st_val[SPC_ST_B6] = txc_flag_ff;
      st_val[SPC_ST_DRE] = dre_flag_ff;
      st_val[SPC_ST_SS] = ssl_flag_ff;
      st_val[SPC_ST_OVF] = ovf_flag_ff;
    end else begin
      st_val[SPC_ST_B7] = xfer_flag_ff;
      st_val[SPC_ST_B6] = wcol_flag_ff;
    end
    rd_ok = 1'b1;
    case (axi_req_in.araddr[7:2])
      SPC_IDX_CTRL: rd_val = ctrl_ff;
      SPC_IDX_IRQ: rd_val = irqc_ff;
      SPC_IDX_STAT: rd_val = st_val;
      SPC_IDX_CTRL2: rd_val = ctrl2_ff;
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // bus response channels
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.awready <= ~aw_got_ff &
        ~(axi_req_in.awvalid & rsp_ff.awready);
      rsp_ff.wready <= ~w_got_ff & ~(axi_req_in.wvalid & rsp_ff.wready);
      if (do_wr) begin
        rsp_ff.bvalid <= 1'b1;
        rsp_ff.bresp <= (aw_idx_ff == SPC_IDX_CTRL ||
          aw_idx_ff == SPC_IDX_IRQ || aw_idx_ff == SPC_IDX_STAT ||
          aw_idx_ff == SPC_IDX_CTRL2) ? SPC_RESP_OK : SPC_RESP_ERR;
      end else if (axi_req_in.bready) begin
        rsp_ff.bvalid <= 1'b0;
      end
      if (ar_take) begin
        rsp_ff.arready <= 1'b0;
        rsp_ff.rvalid <= 1'b1;
        rsp_ff.rdata <= {24'h000000, rd_val};
        rsp_ff.rresp <= rd_ok ? SPC_RESP_OK : SPC_RESP_ERR;
      end else if (rsp_ff.rvalid && axi_req_in.rready) begin
        rsp_ff.rvalid <= 1'b0;
        rsp_ff.arready <= 1'b1;
      end else if (!rsp_ff.rvalid) begin
        rsp_ff.arready <= 1'b1;
      end
    end
  end

  // control registers, master bit dropped on select loss
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= SPC_RST_CTRL;
      irqc_ff <= SPC_RST_IRQ;
      ctrl2_ff <= SPC_RST_CTRL2;
    end else begin
      if (do_wr && wstrb0_ff) begin
        case (aw_idx_ff)
          SPC_IDX_CTRL: ctrl_ff <= wdata_ff; // RL5 RL6 RL7 RL9
          // upper enables writable only in buffered modes
          SPC_IDX_IRQ: irqc_ff <= buffered ? {wdata_ff[7:4], 2'h0,
            wdata_ff[1:0]} : {6'h00, wdata_ff[1:0]}; // RL14 RL19
          SPC_IDX_CTRL2: ctrl2_ff <= {wdata_ff[7:6], 3'h0,
            wdata_ff[2], 2'h0};
          default: ;
        endcase
      end
      if (sel_lost) begin
        ctrl_ff[SPC_CTRL_MASTER] <= 1'b0; // RL8
      end
    end
  end

  // unbuffered flags; status read arms the data access clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xfer_flag_ff <= 1'b0;
      wcol_flag_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else begin
      if (st_read) begin
        arm_ff <= xfer_flag_ff | wcol_flag_ff;
      end else if (data_access_in) begin
        arm_ff <= 1'b0;
      end
      if ((ctrl_ff[SPC_CTRL_EN] & byte_done_in) | sel_lost) begin
        xfer_flag_ff <= 1'b1; // RL20
      end else if (vector_ack_in | (arm_ff & data_access_in)) begin
        xfer_flag_ff <= 1'b0; // RL20
      end
      if (ctrl_ff[SPC_CTRL_EN] & wr_collision_in) begin
        wcol_flag_ff <= 1'b1;
      end else if (arm_ff & data_access_in) begin
        wcol_flag_ff <= 1'b0;
      end
    end
  end

  // buffered flags, set wins over write-one clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rxc_flag_ff <= 1'b0;
      txc_flag_ff <= 1'b0;
      dre_flag_ff <= 1'b0;
      ssl_flag_ff <= 1'b0;
      ovf_flag_ff <= 1'b0;
    end else begin
      if (ctrl_ff[SPC_CTRL_EN] & byte_done_in & rx_unread_in) begin
        rxc_flag_ff <= 1'b1; // RL22
      end else if (!rx_unread_in || (do_wr && wstrb0_ff &&
          aw_idx_ff == SPC_IDX_STAT && wdata_ff[SPC_ST_B7])) begin
        rxc_flag_ff <= 1'b0; // RL22
      end
      if (ctrl_ff[SPC_CTRL_EN] & tx_done_in) begin
        txc_flag_ff <= 1'b1;
      end else if (do_wr && wstrb0_ff && aw_idx_ff == SPC_IDX_STAT &&
          wdata_ff[SPC_ST_B6]) begin
        txc_flag_ff <= 1'b0;
      end
      dre_flag_ff <= tx_buf_empty_in;
      if (sel_lost) begin
        ssl_flag_ff <= 1'b1; // RL23
      end else if (do_wr && wstrb0_ff && aw_idx_ff == SPC_IDX_STAT &&
          wdata_ff[SPC_ST_SS]) begin
        ssl_flag_ff <= 1'b0; // RL23
      end
      if (rx_overrun_in) begin
        ovf_flag_ff <= 1'b1;
      end else if (data_access_in) begin
        ovf_flag_ff <= 1'b0;
      end
    end
  end

  // combined interrupt request
  always_comb begin
    if (buffered) begin
      any_src = (irqc_ff[SPC_IRQ_RXC] & rxc_flag_ff) | // RL15
        (irqc_ff[SPC_IRQ_TXC] & txc_flag_ff) | // RL16
        (irqc_ff[SPC_IRQ_DRE] & dre_flag_ff) | // RL17
        (irqc_ff[SPC_IRQ_SS] & ssl_flag_ff); // RL18
    end else begin
      any_src = xfer_flag_ff; // RL14
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (irqc_ff[SPC_IRQ_LVL_LO +: 2] != 2'h0) & any_src; // RL1 RL24
    end
  end

  // slave dma trigger pulses, separate for receive and transmit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dre_prev_ff <= 1'b1; // empty after reset, no false edge
      dma_rx_ff <= 1'b0;
      dma_tx_ff <= 1'b0;
    end else begin
      dre_prev_ff <= tx_buf_empty_in;
      dma_rx_ff <= slave_on & byte_done_in; // RL2 RL3
      dma_tx_ff <= slave_on & (buffered ?
        (tx_buf_empty_in & ~dre_prev_ff) : byte_done_in); // RL2 RL3
    end
  end

  // outputs
  assign axi_rsp_out = rsp_ff;
  assign enable_out = ctrl_ff[SPC_CTRL_EN]; // RL5
  assign master_out = ctrl_ff[SPC_CTRL_MASTER]; // RL7
  assign lsb_first_out = ctrl_ff[SPC_CTRL_DATA_ORDER_LSB_FIRST]; // RL6
  assign mode_out = ctrl_ff[SPC_CTRL_MODE_LO +: 2]; // RL9
  assign irq_out = irq_ff;
  assign irq_level_out = irqc_ff[SPC_IRQ_LVL_LO +: 2];
  assign dma_rx_trig_out = dma_rx_ff;
  assign dma_tx_trig_out = dma_tx_ff;

  // helper: cycles since last serial clock toggle
  logic [6:0] tog_cnt_ff;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tog_cnt_ff <= 7'h00;
    end else if (!sck_run) begin
      tog_cnt_ff <= 7'h00;
    end else if (sck_edge_out) begin
      tog_cnt_ff <= 7'h01;
    end else begin
      tog_cnt_ff <= tog_cnt_ff + 7'h01;
    end
  end

  sequence s_lost;
    sel_lost;
  endsequence

  sequence s_pulse_once(sig);
    sig ##1 !sig;
  endsequence

  a_irq_level_gate: assert property (irqc_ff[1:0] == 2'h0 |=> // RL1
    !irq_out) else $error("irq without level");
  a_irq_tx_src: assert property (buffered && irqc_ff[1:0] != 2'h0 && // RL16
    irqc_ff[SPC_IRQ_TXC] && txc_flag_ff |=> irq_out)
    else $error("tx irq missing");
  a_irq_unbuf: assert property (!buffered && irqc_ff[1:0] != 2'h0 |=> // RL14
    irq_out == $past(xfer_flag_ff)) else $error("unbuffered irq wrong");
  a_master_drop: assert property (s_lost |=> !master_out ##0 // RL8
    xfer_flag_ff) else $error("master not dropped");
  a_sel_loss_set: assert property (s_lost |=> ssl_flag_ff) // RL23
    else $error("select loss flag not set");
  a_xfer_set: assert property (enable_out && byte_done_in |=> // RL20
    xfer_flag_ff) else $error("transfer flag not set");
  a_dma_rx_pulse: assert property (slave_on && byte_done_in ##1 // RL2
    !byte_done_in |-> s_pulse_once(dma_rx_trig_out))
    else $error("rx dma pulse wrong");
  a_dma_off_dis: assert property (!enable_out |=> // RL5
    !dma_rx_trig_out && !dma_tx_trig_out) else $error("dma while disabled");
  a_sck_idle: assert property (!sck_run [*2] |-> // RL10
    sck_out == $past(mode_out[1])) else $error("sck idle level wrong");
  a_sck_rate: assert property (sck_run && $past(sck_run) && // RL11
    sck_edge_out && $stable(half) |-> tog_cnt_ff == half)
    else $error("sck half period wrong");

endmodule
`default_nettype wire

// ===== spc_pkg.sv
// constants and carrier types for the serial peripheral control block
package spc_pkg;

  // register word indices; byte address is four times the index
  localparam logic [5:0] SPC_IDX_CTRL = 6'h00;
  localparam logic [5:0] SPC_IDX_IRQ = 6'h01;
  localparam logic [5:0] SPC_IDX_STAT = 6'h02;
  localparam logic [5:0] SPC_IDX_CTRL2 = 6'h04;

  // reset values
  localparam logic [7:0] SPC_RST_CTRL = 8'h00;
  localparam logic [7:0] SPC_RST_IRQ = 8'h00;
  localparam logic [7:0] SPC_RST_CTRL2 = 8'h00;

  // link_control field positions
  localparam int SPC_CTRL_CLOCK_DOUBLE = 7;
  localparam int SPC_CTRL_EN = 6;
  localparam int SPC_CTRL_DATA_ORDER_LSB_FIRST = 5;
  localparam int SPC_CTRL_MASTER = 4;
  localparam int SPC_CTRL_MODE_LO = 2;
  localparam int SPC_CTRL_PRE_LO = 0;

  // irq_control field positions
  localparam int SPC_IRQ_RXC = 7;
  localparam int SPC_IRQ_TXC = 6;
  localparam int SPC_IRQ_DRE = 5;
  localparam int SPC_IRQ_SS = 4;
  localparam int SPC_IRQ_LVL_LO = 0;

  // link_status field positions
  localparam int SPC_ST_B7 = 7;
  localparam int SPC_ST_B6 = 6;
  localparam int SPC_ST_DRE = 5;
  localparam int SPC_ST_SS = 4;
  localparam int SPC_ST_OVF = 0;

  // second control register field positions
  localparam int SPC_C2_BUF_LO = 6;
  localparam int SPC_C2_SSD = 2;

  // buffer mode codes
  localparam logic [1:0] SPC_BUF_OFF = 2'h0;
  localparam logic [1:0] SPC_BUF_RSVD = 2'h1;

  // sck half periods in clk cycles, normal and doubled
  localparam logic [6:0] SPC_HALF_N0 = 7'h02;
  localparam logic [6:0] SPC_HALF_N1 = 7'h08;
  localparam logic [6:0] SPC_HALF_N2 = 7'h20;
  localparam logic [6:0] SPC_HALF_N3 = 7'h40;
  localparam logic [6:0] SPC_HALF_D0 = 7'h01;
  localparam logic [6:0] SPC_HALF_D1 = 7'h04;
  localparam logic [6:0] SPC_HALF_D2 = 7'h10;
  localparam logic [6:0] SPC_HALF_D3 = 7'h20;

  // axi responses
  localparam logic [1:0] SPC_RESP_OK = 2'h0;
  localparam logic [1:0] SPC_RESP_ERR = 2'h2;

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } spc_axi_req_s;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } spc_axi_rsp_s;

endpackage

// ===== spc_sck_gen.sv
// master serial clock generator with idle level and rate select
`timescale 1ns/10ps
`default_nettype none
module spc_sck_gen
  import spc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  input wire logic idle_high_in,
  input wire logic [6:0] half_in,
  // serial clock
  output logic sck_out,
  output logic edge_out
);

  logic [6:0] cnt_ff;
  logic sck_ff;
  logic edge_ff;

  // half period counter, idle level held while stopped
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= 7'h00;
      sck_ff <= 1'b0;
      edge_ff <= 1'b0;
    end else if (!run_in) begin
      cnt_ff <= 7'h00;
      sck_ff <= idle_high_in; // RL10
      edge_ff <= 1'b0;
    end else if (cnt_ff == half_in - 7'h01) begin
      cnt_ff <= 7'h00;
      sck_ff <= ~sck_ff;
      edge_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 7'h01;
      edge_ff <= 1'b0;
    end
  end

  assign sck_out = sck_ff;
  assign edge_out = edge_ff;

endmodule
`default_nettype wire

// ===== spc_peer.sv
// far side model: shift engine events and an external select driver
`timescale 1ns/10ps
`default_nettype none
module spc_peer (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // commands from the bench
  input wire logic go_in,
  input wire logic slow_in,
  input wire logic drop_in,
  input wire logic data_access_in,
  // events toward the block
  output logic byte_done_out,
  output logic tx_done_out,
  output logic rx_unread_out,
  output logic tx_buf_empty_out,
  output logic select_n_out
);
  logic [3:0] cnt_ff;
  // one byte takes a short or a long time
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= 4'h0;
      byte_done_out <= 1'b0;
      tx_done_out <= 1'b0;
      tx_buf_empty_out <= 1'b1;
    end else begin
      byte_done_out <= (cnt_ff == 4'h1);
      tx_done_out <= (cnt_ff == 4'h1);
      if (go_in) begin
        cnt_ff <= slow_in ? 4'hC : 4'h2;
        tx_buf_empty_out <= 1'b0;
      end else if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
        if (cnt_ff == 4'h1) tx_buf_empty_out <= 1'b1;
      end
    end
  end
  // byte unread from its done pulse on, until the data register is touched
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) rx_unread_out <= 1'b0;
    else if (cnt_ff == 4'h1) rx_unread_out <= 1'b1;
    else if (data_access_in) rx_unread_out <= 1'b0;
  end
  // another master pulls select low
  assign select_n_out = ~drop_in;
endmodule
`default_nettype wire

// ===== test_serial_peripheral_ctrl_irq.sv
// self-checking bench for the serial peripheral control block
`timescale 1ns/10ps
`default_nettype none
module test_serial_peripheral_ctrl_irq;
  import spc_pkg::*;
  logic clk_in, rst_in, go, slow, drop, dacc, vack, sact, ssin;
  logic bd, txd, rxu, txe, seln, en, ms, lsb, sck, sedge, irq, dmr, dmt;
  logic [1:0] mode, lvl, l, r, br;
  logic [31:0] d;
  logic [7:0] v;
  spc_axi_req_s req;
  spc_axi_rsp_s rsp;
  int err_total, check_count, cyc, n_rx, n_tx, b0, b1;
  spc_ctrl u_spc_ctrl (.clk_in(clk_in), .rst_in(rst_in), .axi_req_in(req),
    .axi_rsp_out(rsp), .byte_done_in(bd), .tx_done_in(txd),
    .wr_collision_in(1'b0), .rx_overrun_in(1'b0), .rx_unread_in(rxu),
    .tx_buf_empty_in(txe), .data_access_in(dacc), .shift_active_in(sact),
    .vector_ack_in(vack), .select_n_in(seln), .select_is_input_in(ssin),
    .enable_out(en), .master_out(ms), .lsb_first_out(lsb), .mode_out(mode),
    .sck_out(sck), .sck_edge_out(sedge), .irq_out(irq),
    .irq_level_out(lvl), .dma_rx_trig_out(dmr), .dma_tx_trig_out(dmt));
  spc_peer u_spc_peer (.clk_in(clk_in), .rst_in(rst_in), .go_in(go),
    .slow_in(slow), .drop_in(drop), .data_access_in(dacc),
    .byte_done_out(bd), .tx_done_out(txd), .rx_unread_out(rxu),
    .tx_buf_empty_out(txe), .select_n_out(seln));
  // clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // hang guard and dma pulse counters
  always @(posedge clk_in) begin
    cyc++;
    n_rx += (dmr === 1'b1);
    n_tx += (dmt === 1'b1);
    if (cyc == 30000) begin
      err_total++;
      end_sim;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // axi write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    bit aw, w;
    @(posedge clk_in);
    aw = 0;
    w = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= {24'h0, dv};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (rsp.awready === 1'b1) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready === 1'b1) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk_in); while (rsp.bvalid !== 1'b1);
    br = rsp.bresp;
    req.bready <= 1'b0;
    tick(2);
  endtask
  // axi read
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge clk_in); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk_in); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task xfer(input bit s);
    slow <= s;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    tick(18);
  endtask
  task pulse_acc(input bit vec);
    dacc <= !vec;
    vack <= vec;
    @(posedge clk_in);
    dacc <= 1'b0;
    vack <= 1'b0;
    tick(3);
  endtask
  // cycles between serial clock toggles
  task automatic rate(input bit dbl, input logic [1:0] p);
    int n;
    int dv[4] = '{4, 16, 64, 128};
    wr(8'h00, {dbl, 3'b101, 2'b00, p});
    sact <= 1'b1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (sedge !== 1'b1 && n < 300);
    n = 0;
    do begin @(posedge clk_in); n++; end while (sedge !== 1'b1 && n < 300);
    chk("sck_half", dv[p] / (dbl ? 4 : 2), n);
    sact <= 1'b0;
  endtask
  // serial clock must not move at all
  task automatic quiet(input logic [7:0] c);
    int n;
    wr(8'h00, c);
    sact <= 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge clk_in);
      n += (sedge === 1'b1);
    end
    chk("sck_quiet", 0, n);
    sact <= 1'b0;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    req = '0;
    {go, slow, drop, dacc, vack, sact, ssin} = '0;
    err_total = 0;
    check_count = 0;
    cyc = 0;
    n_rx = 0;
    n_tx = 0;
    rst_in = 1'b1;
    void'($urandom(32'h4bf4));
    tick(20);
    rst_in <= 1'b0;
    tick(2);
    // reset values and an unmapped word
    for (int i = 0; i < 3; i++) begin
      rd(8'(i * 4));
      chk("reset_val", 32'h0, d);
    end
    chk("irq_idle", 1'b0, irq);
    rd(8'h0C);
    chk("unmapped", {30'h0, SPC_RESP_ERR}, {d[29:0], r});
    wr(8'h0C, 8'h5A);
    chk("wr_unmapped", SPC_RESP_ERR, br);
    $display("test reset done");
    // random control words reach the format outputs
    repeat (6) begin
      v = 8'($urandom);
      wr(8'h00, v);
      chk("wr_ok", SPC_RESP_OK, br);
      rd(8'h00);
      chk("ctrl_rb", {24'h0, v}, d);
      chk("enable", v[6], en);
      chk("master", v[4], ms);
      chk("lsb_first", v[5], lsb);
      chk("mode", v[3:2], mode);
    end
    $display("test format done");
    // idle level per transfer mode
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, {4'h5, 2'(m), 2'b00});
      tick(8);
      chk("sck_idle", m[1], sck);
    end
    for (int i = 0; i < 8; i++) rate(i[2], i[1:0]);
    quiet(8'h13);
    quiet(8'h43);
    $display("test sck done");
    // unbuffered single interrupt and dma triggers in slave mode
    l = 2'($urandom_range(3, 1));
    wr(8'h00, 8'h40);
    wr(8'h04, {6'h3C, l});
    rd(8'h04);
    chk("irq_ro", {30'h0, l}, d);
    chk("irq_lvl", l, lvl);
    b0 = n_rx;
    b1 = n_tx;
    xfer(0);
    chk("dma_rx", b0 + 1, n_rx);
    chk("dma_tx", b1 + 1, n_tx);
    chk("irq_set", 1'b1, irq);
    rd(8'h08);
    chk("xfer_flag", 1'b1, d[7]);
    pulse_acc(0);
    chk("irq_acc", 1'b0, irq);
    xfer(1);
    pulse_acc(1);
    chk("irq_vec", 1'b0, irq);
    wr(8'h04, 8'h00);
    xfer(0);
    chk("irq_lvl0", 1'b0, irq);
    pulse_acc(1);
    $display("test unbuffered done");
    // buffered modes, receive, transmit and empty sources each gated by its own enable
    for (int bm = 2; bm < 4; bm++) begin
      wr(8'h10, {2'(bm), 6'h0});
      wr(8'h04, {6'h20, l});
      rd(8'h04);
      chk("irq_rw", {24'h0, 6'h20, l}, d);
      b0 = n_rx;
      b1 = n_tx;
      xfer(bm[0]);
      chk("bdma_rx", b0 + 1, n_rx);
      chk("bdma_tx", b1 + 1, n_tx);
      chk("irq_rxc", 1'b1, irq);
      wr(8'h04, {6'h0, l});
      chk("irq_mask", 1'b0, irq);
      wr(8'h04, {6'h20, l});
      pulse_acc(0);
      chk("rxc_clr", 1'b0, irq);
      wr(8'h04, {6'h10, l});
      chk("irq_txc", 1'b1, irq);
      wr(8'h08, 8'h40);
      chk("txc_clr", 1'b0, irq);
      wr(8'h04, {6'h08, l});
      chk("irq_dre", 1'b1, irq);
      wr(8'h04, {6'h0, l});
      chk("dre_mask", 1'b0, irq);
    end
    $display("test buffered done");
    // external low on select forces slave operation
    wr(8'h10, 8'h80);
    wr(8'h04, {6'h04, l});
    wr(8'h00, 8'h50);
    ssin <= 1'b1;
    drop <= 1'b1;
    tick(6);
    chk("ms_lost", 1'b0, ms);
    rd(8'h08);
    chk("sel_flag", 1'b1, d[4]);
    chk("irq_sel", 1'b1, irq);
    drop <= 1'b0;
    wr(8'h08, 8'h10);
    chk("sel_clr", 1'b0, irq);
    wr(8'h10, 8'h84);
    wr(8'h00, 8'h50);
    drop <= 1'b1;
    tick(6);
    chk("ms_kept", 1'b1, ms);
    drop <= 1'b0;
    $display("test select done");
    end_sim;
  end
endmodule
`default_nettype wire
